// File: verilog/sac_regs.svh
// Constants for the serial attenuator control link.
// Assumes inclusion by both ends; the package does not include it.
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH
`define SAC_FRAME_BITS      16
`define SAC_BYTE_BITS       8
`define SAC_CH1_CODE        8'h00
`define SAC_CH2_CODE        8'h01
`define SAC_CH3_CODE        8'h02
`define SAC_FINE_LAST       8'h5F
`define SAC_COARSE_FIRST    8'h60
`define SAC_MUTE_FIRST      8'h7F
`define SAC_COARSE_BASE_HDB 8'h60
`define SAC_MUTE_HDB        8'hC8
`define SAC_CLK_DIV         5'h04
`define SAC_CNT_ONE         5'h01
`define SAC_BIT_LAST        5'h0F
`endif

// File: verilog/sac_pkg.sv
// Types shared by both ends of the serial attenuator control link.
// Assumes sac_regs.svh for constants.
package sac_pkg;
   typedef logic [7:0] sac_byte_t;
   typedef logic [7:0] sac_hdb_t;
   typedef enum logic [1:0] {SAC_IDLE, SAC_LOW, SAC_HIGH, SAC_DONE} sac_host_e;
endpackage : sac_pkg

// File: verilog/sac_link_if.sv
// Four-wire link between host and attenuator.
// Assumes a testbench joins the two modports.
`timescale 1ns/100ps
interface sac_link_if;
   logic sclk;
   logic sdata;
   logic latch_n;
   logic chain_out;
   modport host   (output sclk, output sdata, output latch_n,
                   input chain_out);
   modport device (input sclk, input sdata, input latch_n,
                   output chain_out);
endinterface : sac_link_if

// File: verilog/sac_device.sv
// Attenuator end: shift register, latch and channel decode.
// Assumes link pins are asynchronous to clk_sys and sampled here.
//
// Summary of operation
// - Sample data on each serial clock rise.
// - Shift only while latch line is low.
// - Previous frame shifts out the chain output.
// - Host raises latch after all bits.
// - Host holds latch low whole frame.
// - Channel byte precedes attenuation byte.
// - Each byte is sent MSB first.
// - Codes 0 and 1 select channels.
// - Codes to 0x5F give half-dB steps.
// - From 0x60, 48 dB plus 1 dB steps.
// - Codes 0x7F and above mute channel.
// - Power-up mutes every channel.
// - Unknown channel codes change nothing.
// - Mute applies directly from any setting.
// - Chain of n needs 16n bits.
// - Only addressed channel changes setting.
`timescale 1ns/100ps
`include "sac_regs.svh"
module sac_device
   import sac_pkg::*;
(
   input  wire logic     clk_sys,
   input  wire logic     rst,
   input  wire logic     clk_en,
   sac_link_if.device    link,
   output logic [7:0]    ch1_hdb,
   output logic [7:0]    ch2_hdb,
   output logic          ch1_mute,
   output logic          ch2_mute,
   output logic          frame_taken
);
   // Half-dB attenuation from a code.
   function automatic sac_hdb_t code_to_hdb(input sac_byte_t code);
      sac_byte_t step;
      step = code - `SAC_COARSE_FIRST;
      if (code <= `SAC_FINE_LAST) begin
         code_to_hdb = code;
      end else if (code < `SAC_MUTE_FIRST) begin
         // Coarse codes step 1 dB.
         code_to_hdb = `SAC_COARSE_BASE_HDB + {step[6:0], 1'b0};
      end else begin
         code_to_hdb = `SAC_MUTE_HDB;
      end
   endfunction : code_to_hdb

   logic [2:0]  sclk_sy;
   logic [2:0]  sdat_sy;
   logic [2:0]  lat_sy;
   logic        sclk_st_reg, sclk_st_next;
   logic        lat_st_reg,  lat_st_next;
   logic [15:0] shift_reg,   shift_next;
   logic        dout_reg,    dout_next;
   logic [7:0]  h1_reg, h1_next, h2_reg, h2_next;
   logic        m1_reg, m1_next, m2_reg, m2_next;
   logic        tk_reg, tk_next;
   logic        sclk_ok, lat_ok;

   assign sclk_ok = (sclk_sy[1] == sclk_sy[2]);
   assign lat_ok  = (lat_sy[1] == lat_sy[2]);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sclk_sy <= 3'h0;
         sdat_sy <= 3'h0;
         lat_sy  <= 3'h7;
      end else if (clk_en) begin
         sclk_sy <= {sclk_sy[1:0], link.sclk};
         sdat_sy <= {sdat_sy[1:0], link.sdata};
         lat_sy  <= {lat_sy[1:0], link.latch_n};
      end
   end

   always_comb begin
      sclk_st_next = sclk_ok ? sclk_sy[2] : sclk_st_reg;
      lat_st_next  = lat_ok ? lat_sy[2] : lat_st_reg;
      shift_next   = shift_reg;
      dout_next    = dout_reg;
      h1_next      = h1_reg;
      h2_next      = h2_reg;
      m1_next      = m1_reg;
      m2_next      = m2_reg;
      tk_next      = 1'b0;
      // Shift on a filtered clock rise inside a frame.
      if (sclk_st_next && !sclk_st_reg && !lat_st_reg) begin
         dout_next  = shift_reg[15];
         shift_next = {shift_reg[14:0], sdat_sy[2]};
      end
      if (lat_st_next && !lat_st_reg) begin
         tk_next = 1'b1;
         // Upper byte is the channel code, lower the attenuation.
         if (shift_reg[15:8] == `SAC_CH1_CODE) begin
            h1_next = code_to_hdb(shift_reg[7:0]);
            m1_next = (shift_reg[7:0] >= `SAC_MUTE_FIRST);
         end else if (shift_reg[15:8] == `SAC_CH2_CODE) begin
            h2_next = code_to_hdb(shift_reg[7:0]);
            m2_next = (shift_reg[7:0] >= `SAC_MUTE_FIRST);
         end
         // Other codes, including the third channel, leave all alone.
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sclk_st_reg <= 1'b0;
         lat_st_reg  <= 1'b1;
         shift_reg   <= 16'h0000;
         dout_reg    <= 1'b0;
         h1_reg      <= `SAC_MUTE_HDB;
         h2_reg      <= `SAC_MUTE_HDB;
         m1_reg      <= 1'b1;
         m2_reg      <= 1'b1;
         tk_reg      <= 1'b0;
      end else if (clk_en) begin
         sclk_st_reg <= sclk_st_next;
         lat_st_reg  <= lat_st_next;
         shift_reg   <= shift_next;
         dout_reg    <= dout_next;
         h1_reg      <= h1_next;
         h2_reg      <= h2_next;
         m1_reg      <= m1_next;
         m2_reg      <= m2_next;
         tk_reg      <= tk_next;
      end
   end

   assign link.chain_out = dout_reg;
   assign ch1_hdb        = h1_reg;
   assign ch2_hdb        = h2_reg;
   assign ch1_mute       = m1_reg;
   assign ch2_mute       = m2_reg;
   assign frame_taken    = tk_reg;
endmodule : sac_device

// File: verilog/sac_host.sv
// Host end: sends one 16-bit frame per request.
// Assumes the device samples the link with its own clock.
`timescale 1ns/100ps
`include "sac_regs.svh"
module sac_host
   import sac_pkg::*;
(
   input  wire logic     clk_sys,
   input  wire logic     rst,
   input  wire logic     clk_en,
   input  wire logic     req,
   input  wire logic [7:0] chan_code,
   input  wire logic [7:0] atten_code,
   output logic          busy,
   sac_link_if.host      link
);
   sac_host_e   st_reg, st_next;
   logic [15:0] sh_reg, sh_next;
   logic [4:0]  div_reg, div_next;
   logic [4:0]  bit_reg, bit_next;
   logic        sclk_reg, sclk_next;
   logic        lat_reg, lat_next;
   logic        busy_reg, busy_next;

   always_comb begin
      st_next   = st_reg;
      sh_next   = sh_reg;
      div_next  = div_reg;
      bit_next  = bit_reg;
      sclk_next = sclk_reg;
      lat_next  = lat_reg;
      case (st_reg)
         SAC_IDLE: begin
            if (req) begin
               sh_next  = {chan_code, atten_code};
               lat_next = 1'b0;
               div_next = `SAC_CLK_DIV;
               bit_next = 5'h00;
               st_next  = SAC_LOW;
            end
         end
         SAC_LOW: begin
            div_next = div_reg - `SAC_CNT_ONE;
            if (div_reg == 5'h00) begin
               sclk_next = 1'b1;
               div_next  = `SAC_CLK_DIV;
               st_next   = SAC_HIGH;
            end
         end
         SAC_HIGH: begin
            div_next = div_reg - `SAC_CNT_ONE;
            if (div_reg == 5'h00) begin
               sclk_next = 1'b0;
               sh_next   = {sh_reg[14:0], 1'b0};
               div_next  = `SAC_CLK_DIV;
               bit_next  = bit_reg + `SAC_CNT_ONE;
               // Sixteen clock pulses per frame.
               st_next   = (bit_reg == `SAC_BIT_LAST) ? SAC_DONE : SAC_LOW;
            end
         end
         default: begin
            div_next = div_reg - `SAC_CNT_ONE;
            if (div_reg == 5'h00) begin
               lat_next = 1'b1;
               st_next  = SAC_IDLE;
            end
         end
      endcase
      busy_next = (st_next != SAC_IDLE);
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_reg   <= SAC_IDLE;
         sh_reg   <= 16'h0000;
         div_reg  <= 5'h00;
         bit_reg  <= 5'h00;
         sclk_reg <= 1'b0;
         lat_reg  <= 1'b1;
         busy_reg <= 1'b0;
      end else if (clk_en) begin
         st_reg   <= st_next;
         sh_reg   <= sh_next;
         div_reg  <= div_next;
         bit_reg  <= bit_next;
         sclk_reg <= sclk_next;
         lat_reg  <= lat_next;
         busy_reg <= busy_next;
      end
   end

   assign link.sclk    = sclk_reg;
   assign link.sdata   = sh_reg[15];
   assign link.latch_n = lat_reg;
   assign busy         = busy_reg;
endmodule : sac_host

// File: dv/sac_link_properties.sv
// Wire checks on the link joining host and device.
// Assumes tb instantiates it beside that link.
`timescale 1ns/100ps
module sac_link_properties (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic latch_n,
   input wire logic chain_out
);
   logic [4:0] n_rise_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)
         n_rise_reg <= 5'h00;
      else if (latch_n)
         n_rise_reg <= 5'h00;
      else if ($rose(sclk))
         n_rise_reg <= n_rise_reg + 5'h01;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_lead;
      !sclk [*5] ##1 sclk;
   endsequence
   sequence s_high;
      sclk [*5] ##1 !sclk;
   endsequence
   chk_clock_in_frame: assert property (sclk |-> !latch_n)
      else $error("clock high outside frame");
   chk_lead_time: assert property ($fell(latch_n) |-> s_lead)
      else $error("bad lead before first clock");
   chk_half_period: assert property ($rose(sclk) |-> s_high)
      else $error("bad clock high time");
   chk_data_steady: assert property (sclk |-> $stable(sdata))
      else $error("data moved while clock high");
   chk_bit_count: assert property (
      $rose(latch_n) |-> n_rise_reg == 5'h10)
      else $error("frame not sixteen bits");
   chk_latch_last: assert property (
      $rose(latch_n) |-> !sclk && !$past(sclk, 3))
      else $error("latch rose too near clock");
   chk_chain_quiet: assert property (
      latch_n && $past(latch_n) |-> $stable(chain_out))
      else $error("chain moved outside frame");
   chk_chain_step: assert property ($changed(chain_out) |-> !latch_n)
      else $error("chain moved with latch high");
endmodule : sac_link_properties

// File: dv/tb.sv
// Testbench joining host and device, plus a second device driven here.
// Assumes the design files of verilog/ are compiled first.
`timescale 1ns/100ps
module tb;
   import sac_pkg::*;
   logic clk_sys, rst, clk_en, req, busy, tk, tk_b, m1, m2, bm1, bm2, em1, em2;
   logic [7:0] chan_code, atten_code, h1, h2, b1, b2, e1, e2;
   logic [15:0] cap;
   int n_mismatch, n_compared, k;
   int cyc = 0;
   int n_tk = 0;
   int n_tkb = 0;
   localparam logic [15:0] FR [9] = '{16'h0000, 16'h015F, 16'h0060,
      16'h0061, 16'h017E, 16'h007F, 16'h01FF, 16'h0210, 16'h8005};
   sac_link_if lk ();
   sac_link_if lk_b ();
   sac_host u_sac_host (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
      .req(req), .chan_code(chan_code), .atten_code(atten_code),
      .busy(busy), .link(lk));
   sac_device u_sac_device (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
      .link(lk), .ch1_hdb(h1), .ch2_hdb(h2), .ch1_mute(m1), .ch2_mute(m2),
      .frame_taken(tk));
   sac_device u_sac_device_b (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
      .link(lk_b), .ch1_hdb(b1), .ch2_hdb(b2), .ch1_mute(bm1),
      .ch2_mute(bm2), .frame_taken(tk_b));
   sac_link_properties u_sac_link_properties (.clk_sys(clk_sys), .rst(rst),
      .sclk(lk.sclk), .sdata(lk.sdata), .latch_n(lk.latch_n),
      .chain_out(lk.chain_out));
   function logic [7:0] hdb(input logic [7:0] a);
      if (a <= 8'h5F) return a;
      if (a <= 8'h7E) return 8'h60 + ((a - 8'h60) << 1);
      return 8'hC8;
   endfunction : hdb
   task summarize;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task check_all;
      check(h1, e1);
      check(h2, e2);
      check({7'h00, m1}, {7'h00, em1});
      check({7'h00, m2}, {7'h00, em2});
   endtask : check_all
   task send(input logic [7:0] c, input logic [7:0] a);
      int i;
      @(posedge clk_sys);
      req <= 1'b1;
      chan_code <= c;
      atten_code <= a;
      @(posedge clk_sys);
      req <= 1'b0;
      @(negedge clk_sys);
      for (i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk_sys);
      repeat (8) @(negedge clk_sys);
      if (c == 8'h00) begin
         e1 = hdb(a);
         em1 = (a >= 8'h7F);
      end else if (c == 8'h01) begin
         e2 = hdb(a);
         em2 = (a >= 8'h7F);
      end
   endtask : send
   task bang(input logic [15:0] f, input logic hold_hi);
      int i;
      @(posedge clk_sys);
      lk_b.latch_n <= hold_hi;
      for (i = 15; i >= 0; i--) begin
         lk_b.sdata <= f[i];
         repeat (4) @(posedge clk_sys);
         lk_b.sclk <= 1'b1;
         repeat (5) @(posedge clk_sys);
         cap = {cap[14:0], lk_b.chain_out};
         lk_b.sclk <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
      lk_b.latch_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      lk_b.latch_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
   endtask : bang
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (tk === 1'b1)
         n_tk <= n_tk + 1;
      if (tk_b === 1'b1)
         n_tkb <= n_tkb + 1;
      if (cyc == 6000) begin
         n_mismatch++;
         summarize();
      end
   end
   initial begin
      {rst, clk_en, req, chan_code, atten_code, cap} = {3'b110, 32'h0};
      {lk_b.sclk, lk_b.sdata, lk_b.latch_n} = 3'b001;
      {e1, e2, em1, em2} = {8'hC8, 8'hC8, 2'b11};
      {n_mismatch, n_compared} = 0;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      @(negedge clk_sys);
      check_all();
      for (k = 0; k < 9; k++) begin
         send(FR[k][15:8], FR[k][7:0]);
         check_all();
         check_all();
         check({7'h00, busy}, 8'h00);
      end
      bang(16'h0010, 1'b0);
      check(b1, 8'h10);
      bang(16'h007F, 1'b1);
      check(b1, 8'h10);
      bang(16'h0120, 1'b0);
      check(cap[15:8], 8'h00);
      check(cap[7:0], 8'h10);
      check(b2, 8'h20);
      clk_en <= 1'b0;
      bang(16'h0030, 1'b0);
      check(b1, 8'h10);
      clk_en <= 1'b1;
      repeat (8) @(posedge clk_sys);
      check(n_tk[7:0], 8'h09);
      check(n_tkb[7:0], 8'h03);
      summarize();
   end
endmodule : tb
